// ==== advanced_sector_protection.v ====
// Sector protection core: mode select, lock flag, solid/dynamic bits, password unlock
// Behaviour
// - Two-bit one-time mode register; a programmed mode bit fixes that mode forever.
// - Writing both mode bits to zero at once is aborted.
// - Bit 2 zero selects password, bit 1 zero solid; both default one.
// - Once a mode bit is zero, further mode writes fail and set program-fail.
// - Volatile lock flag, 1 unlocked; defaults 1 in solid, 0 in password mode.
// - In solid mode only reset or power-up unlocks the lock flag.
// - Solid bits per sector: set one at a time, erased all together.
// - Solid bit reads FFh when protected, 00h when not; default 00h.
// - While locked, solid program or erase times out leaving bits unchanged.
// - Password mode unlock needs the correct 64-bit password; effective after 2us.
// - Dynamic bit per sector, FFh after reset, set by dynamic write of FFh, cleared by any other byte.
// - Protected when dynamic bit set, or solid and temporary unprotect both set.
// - Temporary unprotect bit volatile, default one, freely rewritable, reset restores.
// - Gang lock/unlock set or clear all dynamic bits, only after advanced select.
// - Gang commands need a preceding write enable, else ignored.
// - Gang opcode accepted as 8 single-line clocks or 2 quad clocks.
// - Gang command not ending on a byte boundary is rejected.
// - After password mode is chosen the password is unreadable and unprogrammable.
// - Password ships all ones; writes only clear bits; any value is valid.
// - Password mode forces lock flag to locked after reset; power-up loads the lock flag with 1, unlocked.
// - Program or erase on a protected sector is ignored, contents unchanged.
// - Wrong password sets program-fail and sets write-in-progress until the retry delay ends.
// - Wrong password holds busy 100us; correct password skips that delay.
// - After advanced select, all sectors start protected by dynamic bits.
`timescale 1ns/1ps
`include "asp_map.vh"

module advanced_sector_protection #(
  parameter SECTORS = 16,
  parameter SECTOR_W = 4
) (
  // Clock, reset, enable
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_ce,
  input wire i_vol_reset,
  // Decoded command from the serial front end
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_op,
  input wire i_cmd_quad,
  input wire [7:0] i_cmd_clocks,
  input wire [SECTOR_W-1:0] i_cmd_sector,
  input wire [63:0] i_cmd_data,
  // Read answer
  output reg o_rd_valid,
  output reg [63:0] o_rd_data,
  // Status
  output reg o_wip,
  output reg o_wel,
  output reg o_p_fail,
  output reg o_e_fail,
  output reg o_adv_sel,
  output reg o_lock_flag,
  output reg [SECTORS-1:0] o_sector_protected,
  // Array operation launch
  output reg o_array_prog,
  output reg o_array_erase,
  output reg [SECTOR_W-1:0] o_array_sector
);

  // ----------------------------------------
  // States and counts
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  // Integer counts cut to the counter width on purpose
  localparam integer UNLOCK_INT = `ASP_UNLOCK_CYC;
  localparam integer RETRY_INT = `ASP_RETRY_CYC;
  localparam integer BUSY_INT = `ASP_BUSY_CYC;
  localparam [11:0] UNLOCK_CYC = UNLOCK_INT[11:0];
  localparam [11:0] RETRY_CYC = RETRY_INT[11:0];
  localparam [11:0] BUSY_CYC = BUSY_INT[11:0];
  localparam [11:0] CNT_ONE = 12'h001;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg state;
  reg [11:0] busy_cnt;
  reg pend_unlock;
  reg mode_solid;
  reg mode_pass;
  reg [63:0] password;
  reg [SECTORS-1:0] solid_bits;
  reg [SECTORS-1:0] dyn_bits;
  reg temp_unprot;
  wire [SECTORS-1:0] prot_vec;
  wire cmd_take;
  wire wr_ok;
  wire mode_fixed;
  wire gang_framed;
  wire [7:0] d_byte;

  // Byte shown for one protection bit
  function [7:0] prot_byte;
    input bit_in;
    begin
      prot_byte = bit_in ? `ASP_BYTE_PROT : `ASP_BYTE_UNPROT;
    end
  endfunction

  // ----------------------------------------
  // Protection truth table per sector
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < SECTORS; g = g + 1) begin : g_prot
      // Dynamic bit, or solid bit while temporary unprotect is one
      assign prot_vec[g] = o_adv_sel & (dyn_bits[g] | (solid_bits[g] & temp_unprot));
    end
  endgenerate

  // Command qualifiers
  assign cmd_take = i_cmd_valid & (state == ST_IDLE);
  assign wr_ok = o_wel & o_adv_sel;
  assign mode_fixed = ~mode_solid | ~mode_pass;
  assign gang_framed = i_cmd_quad ? (i_cmd_clocks == `ASP_QUAD_OP_CLKS) : (i_cmd_clocks == `ASP_SINGLE_OP_CLKS);
  assign d_byte = i_cmd_data[7:0];

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      // Power-up: shipping state for one-time bits, defaults for volatile ones
      state <= ST_IDLE;
      busy_cnt <= 12'h000;
      pend_unlock <= 1'b0;
      mode_solid <= 1'b1;
      mode_pass <= 1'b1;
      password <= `ASP_PASS_RESET;
      solid_bits <= {SECTORS{1'b0}};
      dyn_bits <= {SECTORS{1'b1}};
      temp_unprot <= 1'b1;
      o_rd_valid <= 1'b0;
      o_rd_data <= 64'h0000000000000000;
      o_wip <= 1'b0;
      o_wel <= 1'b0;
      o_p_fail <= 1'b0;
      o_e_fail <= 1'b0;
      o_adv_sel <= 1'b0;
      o_lock_flag <= 1'b1;
      o_sector_protected <= {SECTORS{1'b0}};
      o_array_prog <= 1'b0;
      o_array_erase <= 1'b0;
      o_array_sector <= {SECTOR_W{1'b0}};
    end else if (i_ce) begin
      o_rd_valid <= 1'b0;
      o_array_prog <= 1'b0;
      o_array_erase <= 1'b0;
      o_sector_protected <= prot_vec;
      if (i_vol_reset) begin
        // Reset command or hardware reset: volatile bits to defaults
        state <= ST_IDLE;
        busy_cnt <= 12'h000;
        pend_unlock <= 1'b0;
        dyn_bits <= {SECTORS{1'b1}};
        temp_unprot <= 1'b1;
        o_lock_flag <= mode_pass;
        o_wip <= 1'b0;
        o_wel <= 1'b0;
        o_p_fail <= 1'b0;
        o_e_fail <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (cmd_take) begin
              case (i_cmd_op)
                `ASP_OP_WRITE_ENABLE: begin
                  o_wel <= 1'b1;
                end
                `ASP_OP_ADV_SELECT: begin
                  // One-time switch into advanced sector protection
                  if (o_wel) begin
                    o_adv_sel <= 1'b1;
                    o_wel <= 1'b0;
                  end
                end
                `ASP_OP_MODE_WRITE: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    if (mode_fixed) begin
                      o_p_fail <= 1'b1;
                    end else if (~i_cmd_data[`ASP_MODE_PASS_BIT] & ~i_cmd_data[`ASP_MODE_SOLID_BIT]) begin
                      o_p_fail <= 1'b1;
                    end else begin
                      // One-time bits only move from one to zero
                      mode_pass <= mode_pass & i_cmd_data[`ASP_MODE_PASS_BIT];
                      mode_solid <= mode_solid & i_cmd_data[`ASP_MODE_SOLID_BIT];
                      o_p_fail <= 1'b0;
                    end
                  end
                end
                `ASP_OP_MODE_READ: begin
                  if (o_adv_sel) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {61'h0, mode_pass, mode_solid, 1'b0};
                  end
                end
                `ASP_OP_PASS_WRITE: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    if (~mode_pass) begin
                      o_p_fail <= 1'b1;
                    end else begin
                      password <= password & i_cmd_data;
                      o_p_fail <= 1'b0;
                    end
                  end
                end
                `ASP_OP_PASS_READ: begin
                  // Password hidden once password mode is chosen
                  if (o_adv_sel & mode_pass) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= password;
                  end
                end
                `ASP_OP_PASS_UNLOCK: begin
                  if (o_adv_sel & ~mode_pass) begin
                    state <= ST_BUSY;
                    o_wip <= 1'b1;
                    if (i_cmd_data == password) begin
                      busy_cnt <= UNLOCK_CYC;
                      pend_unlock <= 1'b1;
                      o_p_fail <= 1'b0;
                    end else begin
                      busy_cnt <= RETRY_CYC;
                      pend_unlock <= 1'b0;
                      o_p_fail <= 1'b1;
                    end
                  end
                end
                `ASP_OP_LOCK_SET: begin
                  if (o_adv_sel) begin
                    o_lock_flag <= 1'b0;
                  end
                end
                `ASP_OP_LOCK_READ: begin
                  if (o_adv_sel) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {63'h0, o_lock_flag};
                  end
                end
                `ASP_OP_SOLID_PROG: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    state <= ST_BUSY;
                    busy_cnt <= BUSY_CYC;
                    o_wip <= 1'b1;
                    if (o_lock_flag) begin
                      solid_bits[i_cmd_sector] <= 1'b1;
                      o_p_fail <= 1'b0;
                    end else begin
                      o_p_fail <= 1'b1;
                    end
                  end
                end
                `ASP_OP_SOLID_ERASE: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    state <= ST_BUSY;
                    busy_cnt <= BUSY_CYC;
                    o_wip <= 1'b1;
                    if (o_lock_flag) begin
                      solid_bits <= {SECTORS{1'b0}};
                      o_e_fail <= 1'b0;
                    end else begin
                      o_e_fail <= 1'b1;
                    end
                  end
                end
                `ASP_OP_SOLID_READ: begin
                  if (o_adv_sel) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {56'h0, prot_byte(solid_bits[i_cmd_sector])};
                  end
                end
                `ASP_OP_DYN_WRITE: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    dyn_bits[i_cmd_sector] <= (d_byte == `ASP_BYTE_PROT);
                  end
                end
                `ASP_OP_DYN_READ: begin
                  if (o_adv_sel) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {56'h0, prot_byte(dyn_bits[i_cmd_sector])};
                  end
                end
                `ASP_OP_TEMP_WRITE: begin
                  if (wr_ok) begin
                    o_wel <= 1'b0;
                    temp_unprot <= i_cmd_data[0];
                  end
                end
                `ASP_OP_TEMP_READ: begin
                  if (o_adv_sel) begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {56'h0, prot_byte(temp_unprot)};
                  end
                end
                `ASP_OP_GANG_LOCK: begin
                  // Misframed or unenabled gang commands leave everything alone
                  if (wr_ok & gang_framed) begin
                    o_wel <= 1'b0;
                    dyn_bits <= {SECTORS{1'b1}};
                  end
                end
                `ASP_OP_GANG_UNLOCK: begin
                  if (wr_ok & gang_framed) begin
                    o_wel <= 1'b0;
                    dyn_bits <= {SECTORS{1'b0}};
                  end
                end
                `ASP_OP_ARRAY_PROG: begin
                  if (o_wel) begin
                    o_wel <= 1'b0;
                    state <= ST_BUSY;
                    busy_cnt <= BUSY_CYC;
                    o_wip <= 1'b1;
                    if (prot_vec[i_cmd_sector]) begin
                      o_p_fail <= 1'b1;
                    end else begin
                      o_array_prog <= 1'b1;
                      o_array_sector <= i_cmd_sector;
                      o_p_fail <= 1'b0;
                    end
                  end
                end
                `ASP_OP_ARRAY_ERASE: begin
                  if (o_wel) begin
                    o_wel <= 1'b0;
                    state <= ST_BUSY;
                    busy_cnt <= BUSY_CYC;
                    o_wip <= 1'b1;
                    if (prot_vec[i_cmd_sector]) begin
                      o_e_fail <= 1'b1;
                    end else begin
                      o_array_erase <= 1'b1;
                      o_array_sector <= i_cmd_sector;
                      o_e_fail <= 1'b0;
                    end
                  end
                end
                default: begin
                  o_rd_valid <= 1'b0;
                end
              endcase
            end
          end
          ST_BUSY: begin
            // Count down the busy time, then apply a pending unlock
            if (busy_cnt <= CNT_ONE) begin
              state <= ST_IDLE;
              busy_cnt <= 12'h000;
              o_wip <= 1'b0;
              if (pend_unlock) begin
                o_lock_flag <= 1'b1;
              end
              pend_unlock <= 1'b0;
            end else begin
              busy_cnt <= busy_cnt - CNT_ONE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ==== advanced_sector_protection_props.sv ====
// Port-level assertions for the sector protection core
`timescale 1ns/1ps
`include "asp_map.vh"
module asp_checker #(
  parameter SECTORS = 16,
  parameter SECTOR_W = 4
) (
  // Clock, resets, command
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_ce,
  input wire i_vol_reset,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_op,
  input wire i_cmd_quad,
  input wire [7:0] i_cmd_clocks,
  input wire [SECTOR_W-1:0] i_cmd_sector,
  // Status and launch
  input wire o_wip,
  input wire o_wel,
  input wire o_p_fail,
  input wire o_adv_sel,
  input wire o_lock_flag,
  input wire [SECTORS-1:0] o_sector_protected,
  input wire o_array_prog,
  input wire [SECTOR_W-1:0] o_array_sector
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Command accepted at this edge
  wire taken = i_cmd_valid && i_ce && !o_wip && !i_vol_reset && o_adv_sel;
  wire gang = taken && (i_cmd_op == `ASP_OP_GANG_LOCK || i_cmd_op == `ASP_OP_GANG_UNLOCK);
  wire frame_ok = i_cmd_quad ? i_cmd_clocks == `ASP_QUAD_OP_CLKS : i_cmd_clocks == `ASP_SINGLE_OP_CLKS;
  wire arr = taken && o_wel && i_cmd_op == `ASP_OP_ARRAY_PROG;
  a_vol_reset_prot: assert property (i_vol_reset && i_ce && o_adv_sel |-> ##2 (&o_sector_protected))
    else $error("sectors not protected after volatile reset");
  a_gang_lock_all: assert property (gang && i_cmd_op == `ASP_OP_GANG_LOCK && o_wel && frame_ok
    |-> ##2 (&o_sector_protected))
    else $error("gang lock missed a sector");
  a_gang_no_enable: assert property (gang && !o_wel |-> ##2 (o_sector_protected == $past(o_sector_protected, 2)))
    else $error("gang command acted without write enable");
  a_gang_bad_frame: assert property (gang && o_wel && !frame_ok
    |=> o_wel ##1 (o_sector_protected == $past(o_sector_protected, 2)))
    else $error("misframed gang command acted");
  a_array_blocked: assert property (arr && o_sector_protected[i_cmd_sector] |=> !o_array_prog && o_p_fail)
    else $error("program launched on protected sector");
  a_array_launch: assert property (arr && !o_sector_protected[i_cmd_sector]
    |=> o_array_prog && o_array_sector == $past(i_cmd_sector))
    else $error("program not launched on free sector");
  a_launch_busy: assert property ($rose(o_array_prog) |-> o_wip [*4])
    else $error("busy not held during program");
  a_unlock_result: assert property (taken && i_cmd_op == `ASP_OP_PASS_UNLOCK && !o_lock_flag
    |=> o_p_fail or ##[0:60] (o_lock_flag && !o_wip))
    else $error("unlock neither failed nor completed");
endmodule

// ==== advanced_sector_protection_test.sv ====
// Self-checking bench for the sector protection core
`timescale 1ns/1ps
`include "asp_map.vh"
module advanced_sector_protection_test;
  reg i_clk_sys = 1'b0;
  reg i_rst = 1'b1;
  reg i_vol_reset = 1'b0;
  reg i_ce = 1'b1;
  wire cmd_valid, cmd_quad, rd_valid, write_in_progress_flag, wel, p_fail, e_fail, adv_sel, lock_flag, arr_prog, arr_erase;
  wire [7:0] cmd_op, cmd_clocks;
  wire [3:0] cmd_sector, arr_sector;
  wire [63:0] cmd_data, rd_data;
  wire [15:0] prot;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer launches = 0;
  integer k;
  reg [31:0] rnd = 32'd58;
  reg [15:0] dyn_m, solid_m;
  reg temp_m;
  reg [3:0] s;
  reg [63:0] pw, pass_m;
  // Design and host
  advanced_sector_protection DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_vol_reset(i_vol_reset),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_quad(cmd_quad), .i_cmd_clocks(cmd_clocks),
    .i_cmd_sector(cmd_sector), .i_cmd_data(cmd_data), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_wip(write_in_progress_flag), .o_wel(wel), .o_p_fail(p_fail), .o_e_fail(e_fail), .o_adv_sel(adv_sel),
    .o_lock_flag(lock_flag), .o_sector_protected(prot), .o_array_prog(arr_prog),
    .o_array_erase(arr_erase), .o_array_sector(arr_sector));
  host_cmd_model host (.i_clk_sys(i_clk_sys), .i_busy(write_in_progress_flag), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_quad(cmd_quad), .o_cmd_clocks(cmd_clocks),
    .o_cmd_sector(cmd_sector), .o_cmd_data(cmd_data));
  // Clock and launch counter
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (arr_prog === 1'b1 || arr_erase === 1'b1) begin
      launches <= launches + 1;
    end
  end
  always @(posedge host.hung) begin
    miscompares = miscompares + 1;
    summarize;
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Expected protection from the state table
  function [15:0] prot_of(input [15:0] d, input [15:0] sb, input t);
    prot_of = d | (sb & {16{t}});
  endfunction
  task check(input [8*9-1:0] name, input [63:0] exp, input [63:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && samples_checked > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task op(input [7:0] c, input [3:0] sec, input [63:0] d);
    host.send(c, sec, d, 1'b0, `ASP_SINGLE_OP_CLKS);
  endtask
  task wop(input [7:0] c, input [3:0] sec, input [63:0] d);
    begin
      op(`ASP_OP_WRITE_ENABLE, 4'h0, 64'h0);
      op(c, sec, d);
    end
  endtask
  task rd(input [7:0] c, input [3:0] sec, input [63:0] exp);
    begin
      op(c, sec, 64'h0);
      check("answer", 1, host.got_rd);
      check("read", exp, host.rd_word);
    end
  endtask
  task chk_prot;
    begin
      repeat (2) @(negedge i_clk_sys);
      check("protect", prot_of(dyn_m, solid_m, temp_m), prot);
    end
  endtask
  task vol_reset;
    begin
      @(negedge i_clk_sys);
      i_vol_reset = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_vol_reset = 1'b0;
      dyn_m = 16'hFFFF;
      temp_m = 1'b1;
    end
  endtask
  // Main sequence
  initial begin
    solid_m = 16'h0;
    temp_m = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("lock", 1, lock_flag);
    check("advsel", 0, adv_sel);
    wop(`ASP_OP_ADV_SELECT, 4'h0, 64'h0);
    check("advsel", 1, adv_sel);
    dyn_m = 16'hFFFF;
    chk_prot;
    rnd = xs(rnd);
    s = rnd[3:0];
    rd(`ASP_OP_DYN_READ, s, `ASP_BYTE_PROT);
    rd(`ASP_OP_SOLID_READ, s, `ASP_BYTE_UNPROT);
    i_ce = 1'b0;
    op(`ASP_OP_WRITE_ENABLE, 4'h0, 64'h0);
    check("wel", 0, wel);
    i_ce = 1'b1;
    op(`ASP_OP_GANG_UNLOCK, 4'h0, 64'h0);
    chk_prot;
    op(`ASP_OP_WRITE_ENABLE, 4'h0, 64'h0);
    host.send(`ASP_OP_GANG_UNLOCK, 4'h0, 64'h0, 1'b0, 8'h07);
    chk_prot;
    host.send(`ASP_OP_GANG_UNLOCK, 4'h0, {32'h0, rnd}, 1'b1, `ASP_QUAD_OP_CLKS);
    dyn_m = 16'h0;
    chk_prot;
    wop(`ASP_OP_GANG_LOCK, 4'h0, 64'h0);
    dyn_m = 16'hFFFF;
    chk_prot;
    wop(`ASP_OP_GANG_UNLOCK, 4'h0, 64'h0);
    dyn_m = 16'h0;
    chk_prot;
    wop(`ASP_OP_SOLID_PROG, s, 64'h0);
    solid_m[s] = 1'b1;
    chk_prot;
    rd(`ASP_OP_SOLID_READ, s, `ASP_BYTE_PROT);
    rd(`ASP_OP_SOLID_READ, s ^ 4'h1, `ASP_BYTE_UNPROT);
    for (k = 0; k < 2; k = k + 1) begin
      wop(`ASP_OP_TEMP_WRITE, 4'h0, k);
      temp_m = k;
      chk_prot;
    end
    k = launches;
    wop(`ASP_OP_ARRAY_PROG, s, 64'h0);
    check("pfail", 1, p_fail);
    wop(`ASP_OP_ARRAY_ERASE, s, 64'h0);
    check("efail", 1, e_fail);
    check("launch", k, launches);
    wop(`ASP_OP_ARRAY_PROG, s ^ 4'h1, 64'h0);
    check("launch", k + 1, launches);
    check("sector", s ^ 4'h1, arr_sector);
    wop(`ASP_OP_ARRAY_ERASE, s ^ 4'h1, 64'h0);
    check("launch", k + 2, launches);
    check("efail", 0, e_fail);
    op(`ASP_OP_LOCK_SET, 4'h0, 64'h0);
    rd(`ASP_OP_LOCK_READ, 4'h0, 64'h0);
    wop(`ASP_OP_SOLID_ERASE, 4'h0, 64'h0);
    check("efail", 1, e_fail);
    wop(`ASP_OP_SOLID_PROG, s ^ 4'h2, 64'h0);
    rd(`ASP_OP_SOLID_READ, s, `ASP_BYTE_PROT);
    rd(`ASP_OP_SOLID_READ, s ^ 4'h2, `ASP_BYTE_UNPROT);
    vol_reset;
    check("lock", 1, lock_flag);
    chk_prot;
    wop(`ASP_OP_SOLID_ERASE, 4'h0, 64'h0);
    solid_m = 16'h0;
    rd(`ASP_OP_SOLID_READ, s, `ASP_BYTE_UNPROT);
    for (k = 0; k < 6; k = k + 1) begin
      rnd = xs(rnd);
      wop(`ASP_OP_DYN_WRITE, rnd[3:0], rnd[4] ? 64'hFF : {56'h0, rnd[15:8]});
      dyn_m[rnd[3:0]] = rnd[4] || rnd[15:8] == 8'hFF;
      chk_prot;
    end
    wop(`ASP_OP_MODE_WRITE, 4'h0, 64'h0);
    check("pfail", 1, p_fail);
    rd(`ASP_OP_MODE_READ, 4'h0, 64'h6);
    rnd = xs(rnd);
    pw = {rnd, xs(rnd)};
    pass_m = `ASP_PASS_RESET;
    for (k = 0; k < 2; k = k + 1) begin
      wop(`ASP_OP_PASS_WRITE, 4'h0, pw);
      pass_m = pass_m & pw;
      rd(`ASP_OP_PASS_READ, 4'h0, pass_m);
      pw = {pw[31:0], pw[63:32]};
    end
    wop(`ASP_OP_MODE_WRITE, 4'h0, 64'hFFFB);
    rd(`ASP_OP_MODE_READ, 4'h0, 64'h2);
    wop(`ASP_OP_MODE_WRITE, 4'h0, 64'hFFFD);
    check("pfail", 1, p_fail);
    rd(`ASP_OP_MODE_READ, 4'h0, 64'h2);
    op(`ASP_OP_PASS_READ, 4'h0, 64'h0);
    check("answer", 0, host.got_rd);
    vol_reset;
    check("lock", 0, lock_flag);
    op(`ASP_OP_PASS_UNLOCK, 4'h0, pass_m ^ 64'h1);
    check("pfail", 1, p_fail);
    check("delay", 1, host.busy_n >= (`ASP_RETRY_CYC * 4) / 5);
    op(`ASP_OP_PASS_UNLOCK, 4'h0, pass_m);
    check("lock", 1, lock_flag);
    check("wait", 1, host.busy_n >= `ASP_UNLOCK_CYC - 4);
    check("delay", 1, host.busy_n < `ASP_RETRY_CYC / 2);
    summarize;
  end
endmodule
bind advanced_sector_protection asp_checker #(.SECTORS(SECTORS), .SECTOR_W(SECTOR_W)) chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_vol_reset(i_vol_reset), .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op), .i_cmd_quad(i_cmd_quad), .i_cmd_clocks(i_cmd_clocks), .i_cmd_sector(i_cmd_sector),
  .o_wip(o_wip), .o_wel(o_wel), .o_p_fail(o_p_fail), .o_adv_sel(o_adv_sel), .o_lock_flag(o_lock_flag),
  .o_sector_protected(o_sector_protected), .o_array_prog(o_array_prog), .o_array_sector(o_array_sector));

// ==== asp_map.vh ====
// Command codes, field positions, reset values and timing counts for sector protection
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define ASP_OP_WRITE_ENABLE 8'h06
`define ASP_OP_GANG_LOCK 8'h7E
`define ASP_OP_GANG_UNLOCK 8'h98
`define ASP_OP_ADV_SELECT 8'h68
`define ASP_OP_MODE_WRITE 8'h2C
`define ASP_OP_MODE_READ 8'h2D
`define ASP_OP_PASS_WRITE 8'h28
`define ASP_OP_PASS_READ 8'h27
`define ASP_OP_PASS_UNLOCK 8'h29
`define ASP_OP_LOCK_SET 8'hA6
`define ASP_OP_LOCK_READ 8'hA7
`define ASP_OP_SOLID_PROG 8'hE3
`define ASP_OP_SOLID_ERASE 8'hE4
`define ASP_OP_SOLID_READ 8'hE2
`define ASP_OP_DYN_WRITE 8'hE1
`define ASP_OP_DYN_READ 8'hE0
`define ASP_OP_TEMP_WRITE 8'hE5
`define ASP_OP_TEMP_READ 8'hE6
`define ASP_OP_ARRAY_PROG 8'h02
`define ASP_OP_ARRAY_ERASE 8'h20

// ----------------------------------------
// Mode select fields and reset values
// ----------------------------------------
`define ASP_MODE_SOLID_BIT 1
`define ASP_MODE_PASS_BIT 2
`define ASP_MODE_RESET 2'h3
`define ASP_PASS_RESET 64'hFFFFFFFFFFFFFFFF
`define ASP_BYTE_PROT 8'hFF
`define ASP_BYTE_UNPROT 8'h00

// ----------------------------------------
// Command framing
// ----------------------------------------
`define ASP_SINGLE_OP_CLKS 8'h08
`define ASP_QUAD_OP_CLKS 8'h02

// ----------------------------------------
// Timing
// ----------------------------------------
`define ASP_CLK_NS 50
`define ASP_UNLOCK_NS 2000
`define ASP_UNLOCK_CYC ((`ASP_UNLOCK_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_RETRY_NS 100000
`define ASP_RETRY_CYC ((`ASP_RETRY_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`define ASP_BUSY_CYC 8

`endif

// ==== host_cmd_model.sv ====
// Host controller model issuing decoded commands to the protection core
`timescale 1ns/1ps
module host_cmd_model (
  // Clock and answers
  input wire i_clk_sys,
  input wire i_busy,
  input wire i_rd_valid,
  input wire [63:0] i_rd_data,
  // Command
  output reg o_cmd_valid = 1'b0,
  output reg [7:0] o_cmd_op = 8'h00,
  output reg o_cmd_quad = 1'b0,
  output reg [7:0] o_cmd_clocks = 8'h00,
  output reg [3:0] o_cmd_sector = 4'h0,
  output reg [63:0] o_cmd_data = 64'h0
);
  reg got_rd = 1'b0;
  reg [63:0] rd_word = 64'h0;
  reg hung = 1'b0;
  integer busy_n = 0;
  // Strobe one edge, take the answer while it stands, scramble released payload, poll busy
  task send(input [7:0] op, input [3:0] sec, input [63:0] data, input quad, input [7:0] clks);
    begin
      @(negedge i_clk_sys);
      o_cmd_valid = 1'b1;
      o_cmd_op = op;
      o_cmd_sector = sec;
      o_cmd_data = data;
      o_cmd_quad = quad;
      o_cmd_clocks = clks;
      @(negedge i_clk_sys);
      // Read answer stands only in the cycle after the taking edge
      got_rd = i_rd_valid;
      rd_word = i_rd_data;
      o_cmd_valid = 1'b0;
      o_cmd_op = ~op;
      o_cmd_sector = ~sec;
      o_cmd_data = ~data;
      o_cmd_quad = ~quad;
      o_cmd_clocks = ~clks;
      @(negedge i_clk_sys);
      // Poll busy before the next request may go out
      for (busy_n = 0; busy_n < 3000 && i_busy !== 1'b0; busy_n = busy_n + 1) begin
        @(negedge i_clk_sys);
      end
      hung = (i_busy !== 1'b0);
    end
  endtask
endmodule
